// file: verilog/mdsr_pkg.sv
// constants and helpers for the motor driver status register bank
package mdsr_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int POS_W  = 7;
  localparam int OVC_W  = 4;

  // register offsets
  localparam logic [ADDR_W-1:0] LIVE_FAULT_STATUS_ADDR           = 7'h04;
  localparam logic [ADDR_W-1:0] BRIDGE_X_OVERCURRENT_STATUS_ADDR = 7'h05;
  localparam logic [ADDR_W-1:0] BRIDGE_Y_OVERCURRENT_STATUS_ADDR = 7'h06;
  localparam logic [ADDR_W-1:0] STEP_POSITION_STATUS_ADDR        = 7'h07;

  // field positions
  localparam int PARITY_BIT_POS       = 7;
  localparam int THERMAL_WARNING_POS  = 6;
  localparam int PUMP_FAILURE_POS     = 5;
  localparam int WATCHDOG_EVENT_POS   = 4;
  localparam int OPEN_COIL_X_POS      = 3;
  localparam int OPEN_COIL_Y_POS      = 2;
  localparam int OVERCURRENT_LSB      = 3;
  localparam int THERMAL_SHUTDOWN_POS = 2;

  // values after reset and for unmapped reads
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_VAL = 8'h00;
  localparam logic [POS_W-1:0]  POS_RESET    = 7'h00;

  // read data answers one cycle after the request
  localparam int RD_LATENCY = 1;

  // places even parity of the seven payload bits into bit 7
  function automatic logic [DATA_W-1:0] mdsr_with_parity(
    input logic [DATA_W-2:0] payload
  );
    mdsr_with_parity = {^payload, payload};
  endfunction

endpackage

// file: verilog/mdsr_sticky.sv
// sticky flag bank where a set in the same cycle beats a clear
`timescale 1ns/1ps
module mdsr_sticky #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // set and clear strobes
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  // held flags
  output logic      [W-1:0] o_flag
);

  logic [W-1:0] flag_q;
  logic [W-1:0] flag_d;

  // a fault seen during the clear cycle must not be lost
  assign flag_d = (flag_q & ~i_clr) | i_set;
  assign o_flag = flag_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule // mdsr_sticky

// file: verilog/mdsr_status_regs.sv
// diagnostic status register bank read by the serial port
`timescale 1ns/1ps
module mdsr_status_regs
  import mdsr_pkg::*;
(
  // clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  // watchdog-initiated reset, keeps the watchdog event flag
  input  wire logic                         i_wdog_rst,
  // live conditions from the analog side
  input  wire logic                         i_thermal_warning,
  input  wire logic                         i_pump_undervolt,
  input  wire logic                         i_open_coil_x,
  input  wire logic                         i_open_coil_y,
  input  wire logic [mdsr_pkg::POS_W-1:0]   i_microstep_position,
  // fault events, latched here
  input  wire logic [mdsr_pkg::OVC_W-1:0]   i_overcurrent_x,
  input  wire logic [mdsr_pkg::OVC_W-1:0]   i_overcurrent_y,
  input  wire logic                         i_thermal_shutdown,
  input  wire logic                         i_wdog_timeout,
  // write of the watchdog enable bit
  input  wire logic                         i_wdog_en_wr,
  input  wire logic                         i_wdog_en_val,
  // register read port
  input  wire logic                         i_rd_en,
  input  wire logic [mdsr_pkg::ADDR_W-1:0]  i_rd_addr,
  output logic                              o_rd_valid,
  output logic      [mdsr_pkg::DATA_W-1:0]  o_rd_data,
  // watchdog event flag for the boot logic
  output logic                              o_watchdog_event_flag
);

  import mdsr_pkg::*;

  // live samples
  logic                    thermal_warning_flag_q;
  logic                    pump_failure_flag_q;
  logic                    open_coil_x_flag_q;
  logic                    open_coil_y_flag_q;
  logic [POS_W-1:0]        microstep_position_q;

  // latched flags: {x[3:0], y[3:0], thermal shutdown}
  logic [2*OVC_W:0]        latch_set;
  logic [2*OVC_W:0]        latch_clr;
  logic [2*OVC_W:0]        latch_flags;
  logic [OVC_W-1:0]        overcurrent_x;
  logic [OVC_W-1:0]        overcurrent_y;
  logic                    thermal_shutdown_flag;

  // watchdog
  logic                    wdog_clr;
  logic                    watchdog_event_flag;

  // read path
  logic                    hit_live;
  logic                    hit_bx;
  logic                    hit_by;
  logic                    hit_step;
  logic [DATA_W-1:0]       live_fault_status;
  logic [DATA_W-1:0]       bridge_x_overcurrent_status;
  logic [DATA_W-1:0]       bridge_y_overcurrent_status;
  logic [DATA_W-1:0]       step_position_status;
  logic [DATA_W-1:0]       rd_mux;
  logic [DATA_W-1:0]       rd_data_q;
  logic                    rd_valid_q;

  // live sampling
  // a warm reset clears the live view too; it refills next cycle
  always_ff @(posedge i_clk) begin
    if (i_rst || i_wdog_rst) begin
      thermal_warning_flag_q <= 1'b0;
      pump_failure_flag_q    <= 1'b0;
      open_coil_x_flag_q     <= 1'b0;
      open_coil_y_flag_q     <= 1'b0;
    end else begin
      thermal_warning_flag_q <= i_thermal_warning;
      pump_failure_flag_q    <= i_pump_undervolt;
      open_coil_x_flag_q     <= i_open_coil_x;
      open_coil_y_flag_q     <= i_open_coil_y;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || i_wdog_rst) begin
      microstep_position_q <= POS_RESET;
    end else begin
      microstep_position_q <= i_microstep_position;
    end
  end

  // address decode
  assign hit_live = i_rd_en && (i_rd_addr == LIVE_FAULT_STATUS_ADDR);
  assign hit_bx   = i_rd_en &&
                    (i_rd_addr == BRIDGE_X_OVERCURRENT_STATUS_ADDR);
  assign hit_by   = i_rd_en &&
                    (i_rd_addr == BRIDGE_Y_OVERCURRENT_STATUS_ADDR);
  assign hit_step = i_rd_en && (i_rd_addr == STEP_POSITION_STATUS_ADDR);

  assign latch_set = {i_overcurrent_x, i_overcurrent_y, i_thermal_shutdown};
  assign latch_clr = {{OVC_W{hit_bx || i_wdog_rst}},
                      {(OVC_W+1){hit_by || i_wdog_rst}}};

  mdsr_sticky #(
    .W (2*OVC_W+1)
  ) u_latch (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_set  (latch_set),
    .i_clr  (latch_clr),
    .o_flag (latch_flags)
  );

  assign overcurrent_x         = latch_flags[2*OVC_W:OVC_W+1];
  assign overcurrent_y         = latch_flags[OVC_W:1];
  assign thermal_shutdown_flag = latch_flags[0];

  // only a zero written to the enable bit clears
  assign wdog_clr = i_wdog_en_wr && !i_wdog_en_val;

  // set on timeout, untouched by the warm reset
  mdsr_sticky #(
    .W (1)
  ) u_wdog (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_set  (i_wdog_timeout),
    .i_clr  (wdog_clr),
    .o_flag (watchdog_event_flag)
  );

  assign o_watchdog_event_flag = watchdog_event_flag;

  assign live_fault_status = mdsr_with_parity({thermal_warning_flag_q,
    pump_failure_flag_q, watchdog_event_flag, open_coil_x_flag_q,
    open_coil_y_flag_q, 2'b00});
  assign bridge_x_overcurrent_status =
    mdsr_with_parity({overcurrent_x, 3'b000});
  assign bridge_y_overcurrent_status =
    mdsr_with_parity({overcurrent_y, thermal_shutdown_flag, 2'b00});
  assign step_position_status = mdsr_with_parity(microstep_position_q);

  assign rd_mux = hit_live ? live_fault_status :
                  hit_bx   ? bridge_x_overcurrent_status :
                  hit_by   ? bridge_y_overcurrent_status :
                  hit_step ? step_position_status :
                  UNMAPPED_VAL;

  // read-only: the only write reaching these images is a zero to the watchdog enable bit, which clears the watchdog event bit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_data_q  <= STATUS_RESET;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q  <= i_rd_en ? rd_mux : rd_data_q;
      rd_valid_q <= i_rd_en;
    end
  end

  assign o_rd_data  = rd_data_q;
  assign o_rd_valid = rd_valid_q;

  // ---------------- assertions ----------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  property p_reset_zero;
    disable iff (1'b0)
    i_rst |=> (latch_flags == '0) && !watchdog_event_flag &&
              (microstep_position_q == POS_RESET) && !o_rd_valid &&
              (o_rd_data == STATUS_RESET);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("status not cleared by reset");

  property p_read_answer;
    i_rd_en |=> o_rd_valid ##0 !$stable(o_rd_valid) or $past(o_rd_valid);
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer missing");

  property p_live_mirror;
    !i_wdog_rst |=> (live_fault_status[THERMAL_WARNING_POS] ==
      $past(i_thermal_warning)) &&
      (live_fault_status[PUMP_FAILURE_POS] == $past(i_pump_undervolt)) &&
      (live_fault_status[OPEN_COIL_X_POS] == $past(i_open_coil_x)) &&
      (live_fault_status[OPEN_COIL_Y_POS] == $past(i_open_coil_y));
  endproperty
  a_live_mirror: assert property (p_live_mirror)
    else $error("live fault bits do not follow inputs");

  property p_pump_read;
    hit_live && !$past(i_wdog_rst) && !$past(i_rst)
      |=> o_rd_data[PUMP_FAILURE_POS] == $past(i_pump_undervolt, 2);
  endproperty
  a_pump_read: assert property (p_pump_read)
    else $error("pump failure read wrong");

  property p_ovc_set;
    i_overcurrent_x[0] |=> overcurrent_x[0] ##1
      (overcurrent_x[0] || $past(hit_bx || i_wdog_rst));
  endproperty
  a_ovc_set: assert property (p_ovc_set)
    else $error("overcurrent not latched");

  property p_ovc_hold;
    overcurrent_y[3] && !hit_by && !i_wdog_rst |=> overcurrent_y[3];
  endproperty
  a_ovc_hold: assert property (p_ovc_hold)
    else $error("latched flag lost without read");

  property p_x_read_clear;
    hit_bx && !i_wdog_rst && (i_overcurrent_x == '0)
      |=> (overcurrent_x == '0) &&
          (o_rd_data[OVERCURRENT_LSB+:OVC_W] == $past(overcurrent_x));
  endproperty
  a_x_read_clear: assert property (p_x_read_clear)
    else $error("bridge x read did not return and clear");

  property p_y_read_clear;
    hit_by && !i_wdog_rst && (i_overcurrent_y == '0) && !i_thermal_shutdown
      |=> (overcurrent_y == '0) && !thermal_shutdown_flag &&
          (o_rd_data[OVERCURRENT_LSB+:OVC_W] == $past(overcurrent_y)) &&
          (o_rd_data[THERMAL_SHUTDOWN_POS] == $past(thermal_shutdown_flag));
  endproperty
  a_y_read_clear: assert property (p_y_read_clear)
    else $error("bridge y read did not return and clear");

  property p_tshut_set;
    i_thermal_shutdown |=> thermal_shutdown_flag;
  endproperty
  a_tshut_set: assert property (p_tshut_set)
    else $error("thermal shutdown not latched");

  property p_unmapped;
    i_rd_en && !hit_live && !hit_bx && !hit_by && !hit_step
      |=> o_rd_data == UNMAPPED_VAL;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_pos_read;
    hit_step |=> o_rd_data[POS_W-1:0] == $past(microstep_position_q);
  endproperty
  a_pos_read: assert property (p_pos_read)
    else $error("position read wrong");

  property p_pos_mirror;
    !i_wdog_rst |=> microstep_position_q == $past(i_microstep_position);
  endproperty
  a_pos_mirror: assert property (p_pos_mirror)
    else $error("position does not mirror translator");

  property p_wdog_set;
    i_wdog_timeout |=> watchdog_event_flag;
  endproperty
  a_wdog_set: assert property (p_wdog_set)
    else $error("watchdog event not flagged");

  property p_wdog_warm;
    watchdog_event_flag && i_wdog_rst && !wdog_clr
      |=> watchdog_event_flag [*2] or ##1 $past(wdog_clr);
  endproperty
  a_wdog_warm: assert property (p_wdog_warm)
    else $error("watchdog flag lost on warm reset");

  property p_wdog_clear_only;
    watchdog_event_flag && !wdog_clr |=> watchdog_event_flag;
  endproperty
  a_wdog_clear_only: assert property (p_wdog_clear_only)
    else $error("watchdog flag cleared without enable write");

  property p_wdog_clear;
    wdog_clr && !i_wdog_timeout |=> !watchdog_event_flag;
  endproperty
  a_wdog_clear: assert property (p_wdog_clear)
    else $error("watchdog flag not cleared by enable write");

  property p_open_coil;
    i_open_coil_x && !i_wdog_rst |=> open_coil_x_flag_q;
  endproperty
  a_open_coil: assert property (p_open_coil)
    else $error("open coil not shown");

  property p_parity;
    o_rd_valid |-> (^o_rd_data) == 1'b0;
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity bit wrong");

  c_ovc_read: cover property (overcurrent_x != '0 ##1 hit_bx);
  c_warm_boot: cover property (i_wdog_timeout ##1 i_wdog_rst ##1
                               hit_live);
  c_wdog_clear: cover property (watchdog_event_flag ##1 wdog_clr);
  c_pos_read: cover property (hit_step ##1 o_rd_data[POS_W-1:0] != '0);

endmodule // mdsr_status_regs

// file: verif/mdsr_master_model.sv
// serial master stand-in issuing status reads and watchdog enable writes
`timescale 1ns/1ps
module mdsr_master_model (
  // clock and enable
  input  wire logic                        i_clk,
  input  wire logic                        i_en,
  // requests toward the status bank
  output logic                             o_rd_en,
  output logic      [mdsr_pkg::ADDR_W-1:0] o_rd_addr,
  output logic                             o_wdog_en_wr,
  output logic                             o_wdog_en_val
);
  import mdsr_pkg::*;
  logic [31:0] lfsr_q = 32'h1d35;
  initial begin
    o_rd_en = 1'b0;
    o_rd_addr = 7'h00;
    o_wdog_en_wr = 1'b0;
    o_wdog_en_val = 1'b0;
  end
  // address wanders even when idle, so a stale value is never trusted
  always @(negedge i_clk) begin
    lfsr_q = lfsr_q ^ (lfsr_q << 13);
    lfsr_q = lfsr_q ^ (lfsr_q >> 17);
    lfsr_q = lfsr_q ^ (lfsr_q << 5);
    o_rd_en <= i_en & lfsr_q[0];
    o_rd_addr <= 7'h03 + 7'(lfsr_q[3:1] % 3'h6);
    o_wdog_en_wr <= i_en & (&lfsr_q[7:5]);
    o_wdog_en_val <= lfsr_q[8];
  end
endmodule // mdsr_master_model

// file: verif/motor_driver_status_registers_test.sv
// self-checking bench for the status register bank
`timescale 1ns/1ps
module motor_driver_status_registers_test;
  import mdsr_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        wrst = 1'b0, twarn = 1'b0, pump = 1'b0, ox = 1'b0;
  logic        oy = 1'b0;
  logic        tshut = 1'b0, wdto = 1'b0, pen = 1'b0, rnd = 1'b0;
  logic [6:0]  pos = 7'h00;
  logic [3:0]  ovx = 4'h0, ovy = 4'h0, m_x, m_y, m_live;
  logic [6:0]  m_pos;
  logic        m_tshut, m_wdog, e_valid;
  logic [7:0]  e_data;
  logic [31:0] seed = 32'h8c63;
  int          err_count = 0;
  int          n_compared = 0;
  wire         rd_en, wen_wr, wen_val, rd_valid, wdog_flag;
  wire  [6:0]  rd_addr;
  wire  [7:0]  rd_data;

  always #2.5 i_clk = ~i_clk;

  mdsr_master_model master_u (.i_clk(i_clk), .i_en(pen), .o_rd_en(rd_en),
    .o_rd_addr(rd_addr), .o_wdog_en_wr(wen_wr), .o_wdog_en_val(wen_val));

  mdsr_status_regs dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_wdog_rst(wrst),
    .i_thermal_warning(twarn), .i_pump_undervolt(pump), .i_open_coil_x(ox),
    .i_open_coil_y(oy), .i_microstep_position(pos), .i_overcurrent_x(ovx),
    .i_overcurrent_y(ovy), .i_thermal_shutdown(tshut),
    .i_wdog_timeout(wdto), .i_wdog_en_wr(wen_wr), .i_wdog_en_val(wen_val),
    .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .o_watchdog_event_flag(wdog_flag));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // expected byte from model state before the read edge, parity on top
  function automatic logic [7:0] img(input logic [6:0] a);
    logic [6:0] p;
    case (a)
      7'h04: p = {m_live[3:2], m_wdog, m_live[1:0], 2'b00};
      7'h05: p = {m_x, 3'b000};
      7'h06: p = {m_y, m_tshut, 2'b00};
      7'h07: p = m_pos;
      default: return 8'h00;
    endcase
    return {^p, p};
  endfunction

  task automatic cmp1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // model step on what the last rising edge sampled, then new stimulus
  always @(negedge i_clk) begin
    if (i_rst) begin
      {m_live, m_pos, m_x, m_y, m_tshut, m_wdog} = '0;
      e_valid = 1'b0;
      e_data = 8'h00;
    end else begin
      e_valid = rd_en;
      if (rd_en) e_data = img(rd_addr);
      // set wins over read or watchdog reset clear
      m_x = ovx | ((wrst || (rd_en && rd_addr == 7'h05)) ? 4'h0 : m_x);
      m_y = ovy | ((wrst || (rd_en && rd_addr == 7'h06)) ? 4'h0 : m_y);
      m_tshut = tshut |
        ((wrst || (rd_en && rd_addr == 7'h06)) ? 1'b0 : m_tshut);
      m_wdog = wdto | ((wen_wr && !wen_val) ? 1'b0 : m_wdog);
      m_live = wrst ? 4'h0 : {twarn, pump, ox, oy};
      m_pos = wrst ? 7'h00 : pos;
    end
    cmp1(rd_valid, e_valid);
    cmp8(rd_data, e_data);
    cmp1(wdog_flag, m_wdog);
    if (rnd) begin
      seed = xs(seed);
      {twarn, pump, ox, oy} <= seed[3:0];
      ovx <= seed[7:4] & seed[11:8] & seed[15:12];
      ovy <= seed[11:8] & seed[15:12] & seed[19:16];
      tshut <= &seed[18:16];
      wdto <= &seed[24:20];
      wrst <= &seed[29:25];
      pos <= seed[31:25];
    end
  end

  initial begin
    repeat (6) @(negedge i_clk);
    i_rst <= 1'b0;
    pen <= 1'b1;
    repeat (40) @(negedge i_clk);
    $display("reset value test done");
    rnd <= 1'b1;
    repeat (3000) @(negedge i_clk);
    $display("random traffic test done");
    i_rst <= 1'b1;
    repeat (2) @(negedge i_clk);
    i_rst <= 1'b0;
    repeat (1000) @(negedge i_clk);
    $display("second reset test done");
    rnd <= 1'b0;
    pen <= 1'b0;
    {twarn, pump, ox, oy, ovx, ovy, tshut, wrst} <= '0;
    wdto <= 1'b1;
    @(negedge i_clk);
    wdto <= 1'b0;
    wrst <= 1'b1;
    repeat (2) @(negedge i_clk);
    wrst <= 1'b0;
    pen <= 1'b1;
    repeat (20) @(negedge i_clk);
    $display("warm boot test done");
    wrap_up();
  end
endmodule // motor_driver_status_registers_test
